/* design/i2c_master_transmit_fsm.sv */
module i2c_master_transmit_fsm
   import i2c_mt_pkg::*;
#(
   parameter int HALF  = HALF_CYCLES,
   parameter int DEPTH = FIFO_DEPTH
) (
   // system clock domain
   input  wire logic              clk,
   input  wire logic              reset,
   input  wire logic              ce,
   // bus control register write
   input  wire logic              ctrl_write,
   input  wire logic              ctrl_enable,
   input  wire logic              ctrl_start,
   input  wire logic              ctrl_stop,
   input  wire logic              ctrl_step_clear,
   // bus data register write
   input  wire logic              data_write,
   input  wire logic [DATA_W-1:0] data_in,
   // register contents
   output logic                   step_done,
   output logic                   write_collision_flag,
   output logic                   enable_bit,
   output logic                   start_request_bit,
   output logic                   stop_request_bit,
   output logic [7:0]             bus_status_reg,
   output logic [DATA_W-1:0]      bus_data_reg,
   output logic                   master_transmit_mode,
   output logic                   master_receive_mode,
   output logic                   unaddressed_slave,
   output logic                   data_ready,
   // link clock domain
   input  wire logic              link_clk,
   input  wire logic              scl_in,
   output logic                   scl_out,
   output logic                   scl_oe,
   input  wire logic              sda_in,
   output logic                   sda_out,
   output logic                   sda_oe
);
   localparam int CW = $clog2(HALF + 1);

   ////////////////////////////////////////////////////////////////////////////////
   // state of both domains

   typedef struct packed {
      logic              step_done;
      logic              collision;
      logic              ena;
      logic              sta;
      logic              sto;
      logic [7:0]        status;
      logic [DATA_W-1:0] data;
      logic              mt;
      logic              mr;
      logic              slave;
      logic              owner;
      logic              pending;
      logic              addr_phase;
      logic              rw;
      logic              stop_cmd;
      logic              req_tog;
      cmd_type           cmd;
      logic [DATA_W-1:0] cmd_byte;
      logic              res_m;
      logic              res_s;
      logic              res_seen;
   } sys_state_type;

   typedef struct packed {
      link_fsm_type      st;
      logic [CW-1:0]     cnt;
      logic [2:0]        bitn;
      logic [DATA_W-1:0] sh;
      cmd_type           kind;
      logic              restart;
      logic              scl_oe;
      logic              sda_oe;
      logic              busy;
      logic              owner;
      logic              scl_m;
      logic              scl_s;
      logic              scl_p;
      logic              sda_m;
      logic              sda_s;
      logic              sda_p;
      logic              req_m;
      logic              req_s;
      logic              req_seen;
      logic              ce_m;
      logic              ce_s;
      res_type           res;
      logic              res_tog;
   } link_state_type;

   sys_state_type     sys;
   sys_state_type     next_sys;
   link_state_type    lk;
   link_state_type    next_lk;

   logic              fifo_in_valid;
   logic              fifo_in_ready;
   logic              fifo_out_valid;
   logic              fifo_out_ready;
   logic [DATA_W-1:0] fifo_out_data;
   logic              launch;
   logic              counting;
   logic              tick;

   ////////////////////////////////////////////////////////////////////////////////
   // bytes written by software wait here until the link takes them

   sync_fifo #(
      .WIDTH (DATA_W),
      .DEPTH (DEPTH)
   ) data_fifo (
      .clk       (clk),
      .reset     (reset),
      .ce        (ce),
      .in_valid  (fifo_in_valid),
      .in_ready  (fifo_in_ready),
      .in_data   (data_in),
      .out_valid (fifo_out_valid),
      .out_ready (fifo_out_ready),
      .out_data  (fifo_out_data)
   );

   ////////////////////////////////////////////////////////////////////////////////
   // system side: register behaviour and step sequencing

   always_comb begin
      next_sys = sys;
      fifo_in_valid = data_write && sys.step_done;
      fifo_out_ready = 1'b0;
      launch = 1'b0;
      next_sys.res_m = lk.res_tog;
      next_sys.res_s = sys.res_m;

      // lk.res is held stable by the link until the next command
      if (sys.res_s != sys.res_seen) begin
         next_sys.res_seen = sys.res_s;
         next_sys.pending = 1'b0;
         if (sys.stop_cmd) begin
            next_sys.sto = 1'b0;
            next_sys.stop_cmd = 1'b0;
         end
         case (lk.res)
            RES_START: begin
               next_sys.status = ST_START;
               next_sys.step_done = 1'b1;
               next_sys.owner = 1'b1;
               next_sys.addr_phase = 1'b1;
            end
            RES_RESTART: begin
               next_sys.status = ST_RESTART;
               next_sys.step_done = 1'b1;
               next_sys.owner = 1'b1;
               next_sys.addr_phase = 1'b1;
            end
            RES_ACK, RES_NACK: begin
               next_sys.step_done = 1'b1;
               next_sys.addr_phase = 1'b0;
               if (sys.addr_phase && sys.rw) begin
                  next_sys.mr = 1'b1;
                  next_sys.mt = 1'b0;
                  next_sys.status = (lk.res == RES_ACK) ? ST_SLAR_ACK : ST_SLAR_NACK;
               end else if (sys.addr_phase) begin
                  next_sys.mt = 1'b1;
                  next_sys.mr = 1'b0;
                  next_sys.status = (lk.res == RES_ACK) ? ST_SLAW_ACK : ST_SLAW_NACK;
               end else begin
                  next_sys.status = (lk.res == RES_ACK) ? ST_DATA_ACK : ST_DATA_NACK;
               end
            end
            RES_ARB: begin
               next_sys.status = ST_ARB_LOST;
               next_sys.step_done = 1'b1;
               next_sys.owner = 1'b0;
               next_sys.mt = 1'b0;
               next_sys.mr = 1'b0;
            end
            RES_STOP: begin
               next_sys.status = ST_IDLE;
               next_sys.owner = 1'b0;
               next_sys.mt = 1'b0;
               next_sys.mr = 1'b0;
            end
            default: begin
            end
         endcase
      end

      // a full fifo refuses the byte the same way a busy step does
      if (data_write) begin
         if (sys.step_done && fifo_in_ready) begin
            next_sys.data = data_in;
            next_sys.collision = 1'b0;
         end else begin
            next_sys.collision = 1'b1;
         end
      end

      if (ctrl_write) begin
         next_sys.ena = ctrl_enable;
         next_sys.sta = ctrl_start;
         next_sys.sto = ctrl_stop;
         // no launch while pending is high, even in the cycle a result clears it, so only one command is ever in flight
         launch = ctrl_enable && ctrl_step_clear && !sys.pending && (sys.step_done || !sys.owner);
         if (launch) begin
            next_sys.step_done = 1'b0;
            next_sys.slave = 1'b0;
            next_sys.cmd = CMD_NONE;
            if (sys.status == ST_ARB_LOST && !ctrl_start) begin
               next_sys.slave = 1'b1;
            end else if (ctrl_start && ctrl_stop && sys.owner) begin
               next_sys.cmd = CMD_STOP_START;
            end else if (ctrl_stop && sys.owner) begin
               next_sys.cmd = CMD_STOP;
            end else if (ctrl_start) begin
               next_sys.cmd = CMD_START;
            end else if (sys.owner) begin
               next_sys.cmd = CMD_BYTE;
               next_sys.cmd_byte = fifo_out_valid ? fifo_out_data : sys.data;
               fifo_out_ready = 1'b1;
               if (sys.addr_phase) begin
                  next_sys.rw = next_sys.cmd_byte[RW_POS];
               end
            end
            if (next_sys.cmd == CMD_NONE) begin
               next_sys.sto = 1'b0;
            end else begin
               next_sys.pending = 1'b1;
               next_sys.req_tog = ~sys.req_tog;
               next_sys.stop_cmd = (next_sys.cmd == CMD_STOP) || (next_sys.cmd == CMD_STOP_START);
            end
         end
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         sys <= '0;
         sys.status <= STATUS_RESET;
      end else if (ce) begin
         sys <= next_sys;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // link side: bit engine on the link clock

   always_comb begin
      next_lk = lk;
      next_lk.scl_m = scl_in;
      next_lk.scl_s = lk.scl_m;
      next_lk.scl_p = lk.scl_s;
      next_lk.sda_m = sda_in;
      next_lk.sda_s = lk.sda_m;
      next_lk.sda_p = lk.sda_s;
      next_lk.req_m = sys.req_tog;
      next_lk.req_s = lk.req_m;
      next_lk.ce_m = ce;
      next_lk.ce_s = lk.ce_m;
      // high phases wait for the clock line, which lets a slave stretch it
      counting = (lk.st inside {LK_START_A, LK_RS_B, LK_BIT_HIGH, LK_ACK_HIGH, LK_STOP_B, LK_STOP_C})
                 ? lk.scl_s : 1'b1;
      tick = counting && (lk.cnt == CW'(HALF - 1));

      if (lk.ce_s) begin
         if (lk.scl_s && lk.scl_p && lk.sda_p && !lk.sda_s) begin
            next_lk.busy = 1'b1;
         end else if (lk.scl_s && lk.scl_p && !lk.sda_p && lk.sda_s) begin
            next_lk.busy = 1'b0;
         end
         if (tick) begin
            next_lk.cnt = '0;
         end else if (counting) begin
            next_lk.cnt = lk.cnt + CW'(1);
         end

         case (lk.st)
            LK_PARK: begin
               next_lk.cnt = '0;
               next_lk.scl_oe = lk.owner;
               next_lk.sda_oe = 1'b0;
               if (lk.req_s != lk.req_seen) begin
                  next_lk.req_seen = lk.req_s;
                  next_lk.kind = sys.cmd;
                  next_lk.restart = lk.owner;
                  case (sys.cmd)
                     CMD_START: begin
                        next_lk.st = lk.owner ? LK_RS_A : LK_WAIT_FREE;
                     end
                     CMD_BYTE: begin
                        next_lk.sh = sys.cmd_byte;
                        next_lk.bitn = 3'h7;
                        next_lk.st = LK_BIT_LOW;
                     end
                     CMD_STOP, CMD_STOP_START: begin
                        next_lk.st = LK_STOP_A;
                     end
                     default: begin
                     end
                  endcase
               end
            end
            LK_WAIT_FREE: begin
               next_lk.cnt = '0;
               next_lk.scl_oe = 1'b0;
               next_lk.sda_oe = 1'b0;
               if (!lk.busy && lk.scl_s && lk.sda_s) begin
                  next_lk.st = LK_START_A;
               end
            end
            LK_START_A: begin
               next_lk.scl_oe = 1'b0;
               next_lk.sda_oe = 1'b1;
               if (tick) begin
                  next_lk.st = LK_START_B;
               end
            end
            LK_START_B: begin
               next_lk.scl_oe = 1'b1;
               if (tick) begin
                  next_lk.owner = 1'b1;
                  next_lk.res = lk.restart ? RES_RESTART : RES_START;
                  next_lk.res_tog = ~lk.res_tog;
                  next_lk.st = LK_PARK;
               end
            end
            LK_RS_A: begin
               next_lk.scl_oe = 1'b1;
               next_lk.sda_oe = 1'b0;
               if (tick) begin
                  next_lk.st = LK_RS_B;
               end
            end
            LK_RS_B: begin
               next_lk.scl_oe = 1'b0;
               if (tick) begin
                  next_lk.st = LK_START_A;
               end
            end
            LK_BIT_LOW: begin
               next_lk.scl_oe = 1'b1;
               // data moves only once the clock line is low, never on its falling edge
               if (lk.scl_oe) begin
                  next_lk.sda_oe = !lk.sh[DATA_W-1];
               end
               if (tick) begin
                  next_lk.st = LK_BIT_HIGH;
               end
            end
            LK_BIT_HIGH: begin
               next_lk.scl_oe = 1'b0;
               if (tick) begin
                  if (!lk.sda_oe && !lk.sda_s) begin
                     next_lk.owner = 1'b0;
                     next_lk.sda_oe = 1'b0;
                     next_lk.res = RES_ARB;
                     next_lk.res_tog = ~lk.res_tog;
                     next_lk.st = LK_PARK;
                  end else begin
                     next_lk.sh = {lk.sh[DATA_W-2:0], 1'b0};
                     next_lk.bitn = lk.bitn - 3'h1;
                     next_lk.st = (lk.bitn == 3'h0) ? LK_ACK_LOW : LK_BIT_LOW;
                  end
               end
            end
            LK_ACK_LOW: begin
               next_lk.scl_oe = 1'b1;
               if (lk.scl_oe) begin
                  next_lk.sda_oe = 1'b0;
               end
               if (tick) begin
                  next_lk.st = LK_ACK_HIGH;
               end
            end
            LK_ACK_HIGH: begin
               next_lk.scl_oe = 1'b0;
               if (tick) begin
                  next_lk.scl_oe = 1'b1;
                  next_lk.res = lk.sda_s ? RES_NACK : RES_ACK;
                  next_lk.res_tog = ~lk.res_tog;
                  next_lk.st = LK_PARK;
               end
            end
            LK_STOP_A: begin
               next_lk.scl_oe = 1'b1;
               next_lk.sda_oe = 1'b1;
               if (tick) begin
                  next_lk.st = LK_STOP_B;
               end
            end
            LK_STOP_B: begin
               next_lk.scl_oe = 1'b0;
               if (tick) begin
                  next_lk.st = LK_STOP_C;
               end
            end
            LK_STOP_C: begin
               next_lk.sda_oe = 1'b0;
               if (tick) begin
                  next_lk.owner = 1'b0;
                  if (lk.kind == CMD_STOP_START) begin
                     next_lk.restart = 1'b0;
                     next_lk.st = LK_WAIT_FREE;
                  end else begin
                     next_lk.res = RES_STOP;
                     next_lk.res_tog = ~lk.res_tog;
                     next_lk.st = LK_PARK;
                  end
               end
            end
            default: begin
               next_lk.st = LK_PARK;
            end
         endcase
      end
   end

   always_ff @(posedge link_clk or posedge reset) begin
      if (reset) begin
         lk <= '0;
         lk.st <= LK_PARK;
      end else begin
         lk <= next_lk;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // outputs; pins are open drain and only ever pull low

   assign step_done            = sys.step_done;
   assign write_collision_flag = sys.collision;
   assign enable_bit           = sys.ena;
   assign start_request_bit    = sys.sta;
   assign stop_request_bit     = sys.sto;
   assign bus_status_reg       = sys.status & STATUS_MASK;
   assign bus_data_reg         = sys.data;
   assign master_transmit_mode = sys.mt;
   assign master_receive_mode  = sys.mr;
   assign unaddressed_slave    = sys.slave;
   assign data_ready           = fifo_in_ready;
   assign scl_out              = 1'b0;
   assign sda_out              = 1'b0;
   assign scl_oe               = lk.scl_oe;
   assign sda_oe               = lk.sda_oe;

endmodule

/* design/i2c_mt_pkg.sv */
package i2c_mt_pkg;

   ////////////////////////////////////////////////////////////////////////////////
   // widths and depths
   localparam int DATA_W     = 8;
   localparam int FIFO_DEPTH = 8;
   localparam int RW_POS     = 0;

   ////////////////////////////////////////////////////////////////////////////////
   // status codes, prescaler field always reads zero
   localparam logic [7:0] ST_START      = 8'h08;
   localparam logic [7:0] ST_RESTART    = 8'h10;
   localparam logic [7:0] ST_SLAW_ACK   = 8'h18;
   localparam logic [7:0] ST_SLAW_NACK  = 8'h20;
   localparam logic [7:0] ST_DATA_ACK   = 8'h28;
   localparam logic [7:0] ST_DATA_NACK  = 8'h30;
   localparam logic [7:0] ST_ARB_LOST   = 8'h38;
   localparam logic [7:0] ST_SLAR_ACK   = 8'h40;
   localparam logic [7:0] ST_SLAR_NACK  = 8'h48;
   localparam logic [7:0] ST_IDLE       = 8'hf8;
   localparam logic [7:0] STATUS_MASK   = 8'hf8;
   localparam logic [7:0] STATUS_RESET  = ST_IDLE;

   ////////////////////////////////////////////////////////////////////////////////
   // bus timing, half a bit period on the link clock
   localparam int BIT_HALF_NS    = 5000;
   localparam int LINK_PERIOD_NS = 32;
   localparam int HALF_CYCLES    = (BIT_HALF_NS + LINK_PERIOD_NS - 1) / LINK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////////
   // commands to the link and results back
   typedef enum logic [2:0] {
      CMD_NONE       = 3'h0,
      CMD_START      = 3'h1,
      CMD_BYTE       = 3'h2,
      CMD_STOP       = 3'h3,
      CMD_STOP_START = 3'h4
   } cmd_type;

   typedef enum logic [2:0] {
      RES_NONE    = 3'h0,
      RES_START   = 3'h1,
      RES_RESTART = 3'h2,
      RES_ACK     = 3'h3,
      RES_NACK    = 3'h4,
      RES_ARB     = 3'h5,
      RES_STOP    = 3'h6
   } res_type;

   typedef enum logic [12:0] {
      LK_PARK      = 13'h0001,
      LK_WAIT_FREE = 13'h0002,
      LK_START_A   = 13'h0004,
      LK_START_B   = 13'h0008,
      LK_RS_A      = 13'h0010,
      LK_RS_B      = 13'h0020,
      LK_BIT_LOW   = 13'h0040,
      LK_BIT_HIGH  = 13'h0080,
      LK_ACK_LOW   = 13'h0100,
      LK_ACK_HIGH  = 13'h0200,
      LK_STOP_A    = 13'h0400,
      LK_STOP_B    = 13'h0800,
      LK_STOP_C    = 13'h1000
   } link_fsm_type;

endpackage

/* design/sync_fifo.sv */
module sync_fifo #(
   parameter int WIDTH = 8,
   parameter int DEPTH = 8
) (
   // clock and reset
   input  wire logic             clk,
   input  wire logic             reset,
   input  wire logic             ce,
   // fill side
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   // drain side
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic [WIDTH-1:0]      out_data
);
   // depth must be a power of two: pointers wrap by their extra bit
   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [DEPTH-1:0][WIDTH-1:0] mem;
      logic [AW:0]                 wr;
      logic [AW:0]                 rd;
   } fifo_state_type;

   fifo_state_type cur;
   fifo_state_type next_cur;
   logic           full;
   logic           empty;

   always_comb begin
      next_cur = cur;
      full = (cur.wr[AW] != cur.rd[AW]) && (cur.wr[AW-1:0] == cur.rd[AW-1:0]);
      empty = (cur.wr == cur.rd);
      if (in_valid && !full) begin
         next_cur.mem[cur.wr[AW-1:0]] = in_data;
         next_cur.wr = cur.wr + (AW+1)'(1);
      end
      if (out_ready && !empty) begin
         next_cur.rd = cur.rd + (AW+1)'(1);
      end
   end

   always_ff @(posedge clk or posedge reset) begin
      if (reset) begin
         cur <= '0;
      end else if (ce) begin
         cur <= next_cur;
      end
   end

   assign in_ready  = !full;
   assign out_valid = !empty;
   assign out_data  = cur.mem[cur.rd[AW-1:0]];

endmodule

/* tb/i2c_mt_assertions.sv */
module i2c_mt_checker (
   // system side
   input wire logic       clk,
   input wire logic       reset,
   input wire logic       ce,
   input wire logic       ctrl_write,
   input wire logic       ctrl_enable,
   input wire logic       ctrl_start,
   input wire logic       ctrl_stop,
   input wire logic       ctrl_step_clear,
   input wire logic       data_write,
   // register contents
   input wire logic       step_done,
   input wire logic       write_collision_flag,
   input wire logic       stop_request_bit,
   input wire logic [7:0] bus_status_reg,
   input wire logic [7:0] bus_data_reg,
   input wire logic       master_transmit_mode,
   input wire logic       unaddressed_slave,
   // link side
   input wire logic       scl_oe
);
   timeunit 1ns;
   timeprecision 100ps;
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   wire clr = ce && ctrl_write && ctrl_enable && ctrl_step_clear && step_done;

   a_status_low_zero: assert property (bus_status_reg[2:0] == 3'h0)
      else $error("status low bits set");
   a_collision_set: assert property (ce && data_write && !step_done |=> write_collision_flag)
      else $error("collision not flagged");
   a_collision_keeps: assert property (ce && data_write && !step_done |=> $stable(bus_data_reg))
      else $error("refused byte stored");
   a_flag_holds: assert property (step_done && !(ctrl_write && ctrl_step_clear) |=> step_done)
      else $error("step flag dropped alone");
   a_hold_clock: assert property (step_done && bus_status_reg inside {8'h18, 8'h20, 8'h28, 8'h30} |-> scl_oe)
      else $error("clock line not held");
   a_step_codes: assert property ($rose(step_done) |->
      bus_status_reg inside {8'h08, 8'h10, 8'h18, 8'h20, 8'h28, 8'h30, 8'h38, 8'h40, 8'h48})
      else $error("bad status code");
   a_stop_clears: assert property (clr && ctrl_stop |-> ##[1:1000] !stop_request_bit)
      else $error("stop request stuck");
   a_mode_tx: assert property ($rose(step_done) && bus_status_reg inside {8'h18, 8'h20} |-> ##[0:2] master_transmit_mode)
      else $error("transmit mode missing");
   a_release_slave: assert property (clr && !ctrl_start && bus_status_reg == 8'h38 |-> ##[1:4] unaddressed_slave)
      else $error("not released to slave");

   c_data_ack: cover property ($rose(step_done) && bus_status_reg == 8'h28);
   c_restart: cover property ($rose(step_done) && bus_status_reg == 8'h10);
   c_arb_lost: cover property ($rose(step_done) && bus_status_reg == 8'h38);
endmodule

bind i2c_master_transmit_fsm i2c_mt_checker u_chk (.*);

/* tb/i2c_slave_model.sv */
module i2c_slave_model (
   // bus levels
   input  wire logic       scl,
   input  wire logic       sda,
   // test controls
   input  wire logic       ack_en,
   input  wire logic       lose,
   // drive and capture
   output logic            sda_low,
   output logic [7:0]      last_byte
);
   timeunit 1ns;
   timeprecision 100ps;
   int         cnt = 0;
   logic [7:0] sh  = 8'h00;
   logic       ack = 1'b0;
   // lose mimics another master pulling data low
   assign sda_low = ack | lose;
   always @(negedge sda) if (scl) cnt = 0;
   always @(posedge scl) begin
      if (cnt < 8) sh = {sh[6:0], sda};
      cnt = cnt + 1;
   end
   always @(negedge scl) begin
      if (cnt == 8) begin
         last_byte = sh;
         ack = ack_en;
      end else if (cnt == 9) begin
         ack = 1'b0;
         cnt = 0;
      end
   end
endmodule

/* tb/i2c_master_transmit_fsm_test.sv */
module i2c_master_transmit_fsm_test;
   timeunit 1ns;
   timeprecision 100ps;
   logic clk = 1'b0, link_clk = 1'b0, reset = 1'b1, ce = 1'b1;
   logic ctrl_write = 1'b0, ctrl_enable = 1'b0, ctrl_start = 1'b0, ctrl_stop = 1'b0, ctrl_step_clear = 1'b0;
   logic data_write = 1'b0, ack_en = 1'b1, lose = 1'b0, sda_low;
   logic [7:0] data_in = 8'h00, bus_status_reg, bus_data_reg, last_byte;
   logic step_done, write_collision_flag, enable_bit, start_request_bit, stop_request_bit;
   logic master_transmit_mode, master_receive_mode, unaddressed_slave, data_ready;
   logic scl_in, scl_out, scl_oe, sda_in, sda_out, sda_oe;
   int   err_count = 0, comparisons = 0, cycles = 0;

   // both lines pulled up, low while any party pulls
   assign scl_in = scl_oe ? scl_out : 1'b1;
   assign sda_in = sda_oe ? sda_out : !sda_low;
   i2c_master_transmit_fsm #(.HALF(4)) u_dut (.*);
   i2c_slave_model u_slave (.scl(scl_in), .sda(sda_in), .ack_en(ack_en), .lose(lose),
                            .sda_low(sda_low), .last_byte(last_byte));
   initial forever #5 clk = ~clk;
   initial begin
      #3;
      forever #16 link_clk = ~link_clk;
   end

   task automatic end_sim;
      $display("errors %0d comparisons %0d", err_count, comparisons);
      if (err_count == 0 && comparisons > 0) $display("== PASSED ==");
      else $display("== FAILED ==");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles++;
      if (cycles == 30000) begin
         err_count++;
         end_sim;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("BAD %0t got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic ctl(input logic e, input logic s, input logic p);
      @(posedge clk) #1;
      {ctrl_write, ctrl_enable, ctrl_start, ctrl_stop, ctrl_step_clear} = {1'b1, e, s, p, 1'b1};
      @(posedge clk) #1 ctrl_write = 1'b0;
   endtask
   task automatic wr(input logic [7:0] b);
      @(posedge clk) #1;
      data_in = b;
      data_write = 1'b1;
      @(posedge clk) #1 data_write = 1'b0;
   endtask
   task automatic step(input logic [7:0] exp);
      for (int n = 0; n < 3000 && step_done !== 1'b1; n++) @(posedge clk) #1;
      chk(step_done, 8'h01);
      chk(bus_status_reg, exp);
   endtask
   task automatic send(input logic [7:0] b, input logic [7:0] exp);
      wr(b);
      ctl(1'b1, 1'b0, 1'b0);
      step(exp);
   endtask

   initial begin
      repeat (16) @(posedge clk);
      #1 reset = 1'b0;
      ctl(1'b1, 1'b1, 1'b0);
      chk(start_request_bit, 8'h01);
      chk(enable_bit, 8'h01);
      wr(8'h55);
      chk(write_collision_flag, 8'h01);
      chk(bus_data_reg, 8'h00);
      chk(data_ready, 8'h01);
      step(8'h08);
      send(8'ha4, 8'h18);
      chk(write_collision_flag, 8'h00);
      chk(bus_data_reg, 8'ha4);
      chk(master_transmit_mode, 8'h01);
      chk(scl_in, 8'h00);
      // a frozen block must ignore a stop request
      ce = 1'b0;
      ctl(1'b1, 1'b0, 1'b1);
      chk(step_done, 8'h01);
      chk(stop_request_bit, 8'h00);
      ce = 1'b1;
      send(8'h3c, 8'h28);
      chk(last_byte, 8'h3c);
      ack_en = 1'b0;
      send(8'hc3, 8'h30);
      ctl(1'b1, 1'b1, 1'b0);
      step(8'h10);
      send(8'ha4, 8'h20);
      ctl(1'b1, 1'b1, 1'b0);
      step(8'h10);
      send(8'ha5, 8'h48);
      chk(master_receive_mode, 8'h01);
      ack_en = 1'b1;
      ctl(1'b1, 1'b1, 1'b1);
      step(8'h08);
      chk(stop_request_bit, 8'h00);
      lose = 1'b1;
      send(8'ha4, 8'h38);
      lose = 1'b0;
      ctl(1'b1, 1'b0, 1'b0);
      for (int n = 0; n < 8 && unaddressed_slave !== 1'b1; n++) @(posedge clk) #1;
      chk(unaddressed_slave, 8'h01);
      ctl(1'b1, 1'b1, 1'b0);
      step(8'h08);
      send(8'ha4, 8'h18);
      ctl(1'b1, 1'b0, 1'b1);
      for (int n = 0; n < 3000 && stop_request_bit !== 1'b0; n++) @(posedge clk) #1;
      chk(bus_status_reg, 8'hf8);
      chk({scl_in, sda_in}, 8'h03);
      end_sim;
   end
endmodule
